/* File: rtl/fsp_serial_port.sv */
// Four-mode serial port: shift-register mode and three async modes
// What this block does
// [RQ1] Mode bits pick one of four modes
// [RQ2] Mode 0 moves 8 bits, drives shift clock
// [RQ3] Mode 0 write loads marker, send after one cycle
// [RQ4] Mode 0 clock low S3-S5, shift at S6P2
// [RQ5] Mode 0 last shift, done at S1P1
// [RQ6] Mode 0 receive loads 1111110 then goes active
// [RQ7] Mode 0 receive samples S5P2, shifts S6P2
// [RQ8] Mode 0 receive final shift, flag at S1P1
// [RQ9] Mode 1 frame: start, 8 data, stop
// [RQ10] Async send starts after next rollover
// [RQ11] Start bit, then data, then first shift
// [RQ12] Mode 1 transmit done at tenth rollover
// [RQ13] Receiver hunts falling edge, resets counter
// [RQ14] Majority vote of samples 7, 8, 9
// [RQ15] False start bit returns to hunting
// [RQ16] Mode 1 load only under flag conditions
// [RQ17] Failed load discards frame, then hunt
// [RQ18] 9-bit frames carry programmable ninth bit
// [RQ19] Fixed or timer-derived baud per mode
// [RQ20] Ninth bit loaded, stop shifted in first
// [RQ21] 9-bit transmit done at eleventh rollover
// [RQ22] Transmit-done flag set, software clears
// [RQ23] Receive-done flag set, software clears
// [RQ24] Multiprocessor enable gates receive-done flag
// [RQ25] 9-bit load needs clear flag, and ninth bit set when multiprocessor enable is set
// [RQ26] Fixed rate doubles with baud_double
// [RQ27] Receive needs enable; buffer write sends
module fsp_serial_port
  import fsp_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic [7:0] SFR_ADDR,
  input  wire logic [7:0] SFR_WDATA,
  input  wire logic       SFR_WR,
  input  wire logic       SFR_BIT_WR,
  input  wire logic [2:0] SFR_BIT_SEL,
  input  wire logic       SFR_BIT_VAL,
  output logic      [7:0] SFR_RDATA,
  input  wire logic       BAUD_DOUBLE,
  input  wire logic       CLK6_MODE,
  input  wire logic       TIMER_OVF,
  input  wire logic       RXD_IN,
  output logic            RXD_OUT,
  output logic            RXD_OE_N,
  output logic            TXD
);

  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] rbuf;
    logic [8:0] tsr;
    fsp_tx_t    tst;
    logic       tdata;
    logic       tfirst;
    logic [3:0] tcnt;
    logic [9:0] rsr;
    fsp_rx_t    rst;
    logic [3:0] rcnt;
    logic [1:0] smp;
    logic       rprev;
    logic       rfirst;
    logic       sy1;
    logic       sy2;
    logic       txd;
    logic       rxd_o;
    logic       rxd_oe_n;
    logic [7:0] rdata;
  } fsp_st_t;

  fsp_st_t s, n;

  logic [3:0] slot;
  logic       tick16;
  logic [1:0] mode;
  logic       roll;
  logic       buf_wr;
  logic       set_ti;
  logic       set_ri;
  logic       bit_v;
  logic       ninth;
  logic       final_sh;
  logic [7:0] data;
  logic [7:0] shifted;
  logic       sclk;

  // ------------------------------------------------------------------
  // Timing source
  // ------------------------------------------------------------------
  // [RQ19] baud source select
  fsp_timing u_timing (
    .clk         (CLK),
    .rst         (RST),
    .clk6_mode   (CLK6_MODE),
    .baud_double (BAUD_DOUBLE),
    .mode        (mode),
    .timer_ovf   (TIMER_OVF),
    .slot        (slot),
    .tick16      (tick16)
  );

  // Slot match; in 6-clock mode one clock covers both phases of a state
  function automatic logic at(input logic [3:0] sl, input logic x2, input logic [3:0] tg);
    return (sl == tg) || (x2 && ((sl + 4'h1) == tg));
  endfunction : at

  // Data arrive LSB first into a left-shifting register, so reverse
  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction : rev8

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    n        = s;
    set_ti   = 1'b0;
    set_ri   = 1'b0;
    bit_v    = 1'b0;
    ninth    = 1'b0;
    final_sh = 1'b0;
    data     = '0;
    shifted  = '0;
    // [RQ1] mode decode
    mode     = {s.ctl[CTL_MODE_HI], s.ctl[CTL_MODE_LO]};
    roll     = tick16 && (s.tcnt == CNT16_LAST);
    buf_wr   = SFR_WR && (SFR_ADDR == BUF_ADDR);
    n.sy1    = RXD_IN;
    n.sy2    = s.sy1;

    // Software writes first, so hardware flag sets below win over clears
    if (SFR_WR && (SFR_ADDR == CTL_ADDR)) begin
      n.ctl = SFR_WDATA;
    end
    if (SFR_BIT_WR && (SFR_ADDR == CTL_ADDR)) begin
      n.ctl[SFR_BIT_SEL] = SFR_BIT_VAL;
    end
    if (tick16) begin
      n.tcnt = s.tcnt + 4'h1;
    end

    // Transmitter
    case (s.tst)
      TX_M0_A: begin
        if (at(slot, CLK6_MODE, SLOT_S1P1)) begin
          n.tst = TX_M0_B;
        end
      end
      // [RQ3] send one full cycle after write
      TX_M0_B: begin
        if (at(slot, CLK6_MODE, SLOT_S6P2)) begin
          n.tst    = TX_SEND;
          n.tfirst = 1'b0;
        end
      end
      // [RQ10] wait for counter rollover
      TX_ARMED: begin
        if (roll) begin
          n.tst = TX_GO;
        end
      end
      TX_GO: begin
        if (at(slot, CLK6_MODE, SLOT_S1P1)) begin
          n.tst    = TX_SEND;
          n.tdata  = 1'b0;
          n.tfirst = 1'b1;
        end
      end
      TX_SEND: begin
        if (mode == MODE_SHIFT) begin
          // [RQ4] shift right at S6P2
          if (at(slot, CLK6_MODE, SLOT_S6P2)) begin
            n.tfirst = 1'b0;
            if (!s.tfirst) begin
              n.tsr = {1'b0, s.tsr[8:1]};
              // [RQ5] marker next to LSB: last shift
              if (s.tsr[8:1] == TX_LAST_PAT) begin
                n.tst = TX_FIN;
              end
            end
          end
        end else if (roll) begin
          // [RQ11] start bit time, then data bit out
          if (!s.tdata) begin
            n.tdata = 1'b1;
          end else begin
            n.tfirst = 1'b0;
            // [RQ20] first shift inserts the stop bit in 9-bit modes
            n.tsr = {s.tfirst && (mode != MODE_8VAR), s.tsr[8:1]};
            // [RQ12] [RQ21] final shift ends the frame; in 9-bit modes the
            // pattern only counts once the stop bit has been shifted in
            if (s.tsr[8:1] == TX_LAST_PAT && !(s.tfirst && mode != MODE_8VAR)) begin
              n.tst  = TX_IDLE;
              set_ti = 1'b1;
            end
          end
        end
      end
      TX_FIN: begin
        if (at(slot, CLK6_MODE, SLOT_S1P1)) begin
          n.tst  = TX_IDLE;
          set_ti = 1'b1;
        end
      end
      default: n.tst = TX_IDLE;
    endcase

    // [RQ27] any buffer write starts a transmission
    if (buf_wr) begin
      // [RQ9] [RQ18] marker or ninth bit above data
      ninth = (mode[1] == 1'b0) ? 1'b1 : s.ctl[CTL_TX_NINTH];
      n.tsr = {ninth, SFR_WDATA};
      n.tst = (mode == MODE_SHIFT) ? TX_M0_A : TX_ARMED;
    end

    // Receiver
    if (tick16) begin
      n.rprev = s.sy2;
    end
    case (s.rst)
      RX_IDLE: begin
        if (mode == MODE_SHIFT) begin
          // [RQ6] enable set and flag clear
          if (s.ctl[CTL_RX_EN] && !s.ctl[CTL_RX_DONE]) begin
            n.rst = RX_M0_A;
          end
        end else if (s.ctl[CTL_RX_EN] && tick16 && s.rprev && !s.sy2) begin
          // [RQ13] falling edge: realign counter, preload
          n.rst    = RX_ASYNC;
          n.rcnt   = 4'h0;
          n.rsr    = {1'b1, RXA_LOAD};
          n.rfirst = 1'b1;
        end
      end
      RX_M0_A: begin
        if (at(slot, CLK6_MODE, SLOT_S1P1)) begin
          n.rst = RX_M0_B;
        end
      end
      // [RQ6] preload at S6P2 of next cycle
      RX_M0_B: begin
        if (at(slot, CLK6_MODE, SLOT_S6P2)) begin
          n.rsr = {3'b111, RX0_LOAD};
          n.rst = RX_M0_GO;
        end
      end
      RX_M0_GO: n.rst = RX_M0;
      RX_M0: begin
        // [RQ7] sample S5P2, shift left S6P2
        if (at(slot, CLK6_MODE, SLOT_S5P2)) begin
          n.smp[0] = s.sy2;
        end
        if (at(slot, CLK6_MODE, SLOT_S6P2)) begin
          shifted = {s.rsr[6:0], n.smp[0]};
          n.rsr   = {s.rsr[8:0], n.smp[0]};
          // [RQ8] zero marker leftmost: load buffer
          if (!s.rsr[7]) begin
            n.rbuf = rev8(shifted);
            n.rst  = RX_M0_FN;
          end
        end
      end
      RX_M0_FN: begin
        if (at(slot, CLK6_MODE, SLOT_S1P1)) begin
          n.rst  = RX_IDLE;
          set_ri = 1'b1;
        end
      end
      RX_ASYNC: begin
        if (tick16) begin
          n.rcnt = s.rcnt + 4'h1;
          // [RQ14] keep samples at states 7 and 8
          if (s.rcnt >= SAMPLE_A && s.rcnt < SAMPLE_C) begin
            n.smp = {s.smp[0], s.sy2};
          end
          if (s.rcnt == SAMPLE_C) begin
            // [RQ14] two of three vote
            bit_v = (s.smp[1] & s.smp[0]) | (s.smp[1] & s.sy2) | (s.smp[0] & s.sy2);
            final_sh = (mode == MODE_8VAR) ? !s.rsr[8] : !s.rsr[9];
            ninth    = (mode == MODE_8VAR) ? bit_v : s.rsr[0];
            data     = (mode == MODE_8VAR) ? s.rsr[7:0] : s.rsr[8:1];
            n.rfirst = 1'b0;
            n.rsr    = {s.rsr[8:0], bit_v};
            if (s.rfirst && bit_v) begin
              // [RQ15] false start bit
              n.rst = RX_IDLE;
            end else if (final_sh) begin
              // [RQ17] always back to hunting
              n.rst = RX_IDLE;
              // [RQ16] [RQ24] [RQ25] load only when allowed
              if (!s.ctl[CTL_RX_DONE] && (!s.ctl[CTL_MP_EN] || ninth)) begin
                n.rbuf              = rev8(data);
                n.ctl[CTL_RX_NINTH] = ninth;
                set_ri              = 1'b1;
              end
            end
          end
        end
      end
      default: n.rst = RX_IDLE;
    endcase

    // [RQ22] [RQ23] hardware set beats software clear
    if (set_ti) begin
      n.ctl[CTL_TX_DONE] = 1'b1;
    end
    if (set_ri) begin
      n.ctl[CTL_RX_DONE] = 1'b1;
    end

    // Pins; the shift clock lags the slot counter by one clock
    // [RQ4] [RQ7] clock low from S3P1 until S6P1
    sclk = !((slot >= SLOT_S3P1) && (slot < SLOT_S6P1));
    if (mode == MODE_SHIFT) begin
      // [RQ2] clock out on transmit line
      n.txd = (n.tst == TX_SEND || n.rst == RX_M0) ? sclk : 1'b1;
    end else begin
      n.txd = (n.tst == TX_SEND) ? (n.tdata & n.tsr[0]) : 1'b1;
    end
    // [RQ2] data out on receive line in mode 0
    n.rxd_o    = n.tsr[0];
    n.rxd_oe_n = !((mode == MODE_SHIFT) && (n.tst == TX_SEND));

    // Read data; unmapped addresses read zero
    if (SFR_ADDR == CTL_ADDR) begin
      n.rdata = n.ctl;
    end else if (SFR_ADDR == BUF_ADDR) begin
      n.rdata = n.rbuf;
    end else begin
      n.rdata = 8'h00;
    end
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s          <= '0;
      s.ctl      <= CTL_RESET;
      s.rbuf     <= BUF_RESET;
      s.tst      <= TX_IDLE;
      s.rst      <= RX_IDLE;
      s.sy1      <= 1'b1;
      s.sy2      <= 1'b1;
      s.rprev    <= 1'b1;
      s.txd      <= 1'b1;
      s.rxd_o    <= 1'b1;
      s.rxd_oe_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign SFR_RDATA = s.rdata;
  assign RXD_OUT   = s.rxd_o;
  assign RXD_OE_N  = s.rxd_oe_n;
  assign TXD       = s.txd;

endmodule : fsp_serial_port

/* File: rtl/fsp_pkg.sv */
// Constants and types shared by the four-mode serial port files
package fsp_pkg;

  // ------------------------------------------------------------------
  // Register addresses and field positions
  // ------------------------------------------------------------------
  localparam logic [7:0] CTL_ADDR      = 8'h98;  // serial_control
  localparam logic [7:0] BUF_ADDR      = 8'h99;  // serial_buffer
  localparam logic [7:0] CTL_RESET     = 8'h00;
  localparam logic [7:0] BUF_RESET     = 8'h00;
  localparam int         CTL_MODE_HI   = 7;
  localparam int         CTL_MODE_LO   = 6;
  localparam int         CTL_MP_EN     = 5;
  localparam int         CTL_RX_EN     = 4;
  localparam int         CTL_TX_NINTH  = 3;
  localparam int         CTL_RX_NINTH  = 2;
  localparam int         CTL_TX_DONE   = 1;
  localparam int         CTL_RX_DONE   = 0;

  // ------------------------------------------------------------------
  // Modes and machine-cycle slots (state*2 + phase, S1P1 = 0)
  // ------------------------------------------------------------------
  localparam logic [1:0] MODE_SHIFT    = 2'h0;
  localparam logic [1:0] MODE_8VAR     = 2'h1;
  localparam logic [1:0] MODE_9FIX     = 2'h2;
  localparam logic [1:0] MODE_9VAR     = 2'h3;
  localparam logic [3:0] SLOT_S1P1     = 4'h0;
  localparam logic [3:0] SLOT_S3P1     = 4'h4;
  localparam logic [3:0] SLOT_S5P2     = 4'h9;
  localparam logic [3:0] SLOT_S6P1     = 4'ha;
  localparam logic [3:0] SLOT_S6P2     = 4'hb;
  localparam logic [3:0] SLOT_LAST     = 4'hb;

  // ------------------------------------------------------------------
  // Timing counts and shift-register loads
  // ------------------------------------------------------------------
  localparam logic [1:0] FIX_DIV_12_N  = 2'h3;  // osc/64: tick every 4 clocks
  localparam logic [1:0] FIX_DIV_12_D  = 2'h1;  // osc/32: tick every 2
  localparam logic [1:0] FIX_DIV_6_N   = 2'h1;  // osc/32 in 6-clock mode
  localparam logic [1:0] FIX_DIV_6_D   = 2'h0;  // osc/16 in 6-clock mode
  localparam logic [3:0] CNT16_LAST    = 4'hf;
  localparam logic [3:0] SAMPLE_A      = 4'h7;
  localparam logic [3:0] SAMPLE_C      = 4'h9;
  localparam logic [6:0] RX0_LOAD      = 7'b1111110;
  localparam logic [8:0] RXA_LOAD      = 9'h1ff;
  localparam logic [7:0] TX_LAST_PAT   = 8'h01;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_M0_A  = 3'b001,
    TX_M0_B  = 3'b010,
    TX_ARMED = 3'b011,
    TX_GO    = 3'b100,
    TX_SEND  = 3'b101,
    TX_FIN   = 3'b110
  } fsp_tx_t;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b000,
    RX_M0_A  = 3'b001,
    RX_M0_B  = 3'b010,
    RX_M0_GO = 3'b011,
    RX_M0    = 3'b100,
    RX_M0_FN = 3'b101,
    RX_ASYNC = 3'b110
  } fsp_rx_t;

endpackage : fsp_pkg

/* File: rtl/fsp_timing.sv */
// Machine-cycle slot counter and 16x baud tick generator
module fsp_timing
  import fsp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       clk6_mode,
  input  wire logic       baud_double,
  input  wire logic [1:0] mode,
  input  wire logic       timer_ovf,
  output logic      [3:0] slot,
  output logic            tick16
);

  typedef struct packed {
    logic [3:0] slot;
    logic [1:0] pre;
    logic       half;
    logic       tick;
  } fsp_tim_t;

  fsp_tim_t s, n;
  logic [1:0] lim;

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  // In 6-clock mode a whole state passes per clock, so slots step by two
  always_comb begin
    n      = s;
    n.tick = 1'b0;
    lim    = clk6_mode ? (baud_double ? FIX_DIV_6_D : FIX_DIV_6_N)
                       : (baud_double ? FIX_DIV_12_D : FIX_DIV_12_N);
    if (clk6_mode) begin
      n.slot = (s.slot >= SLOT_LAST - 4'h2) ? SLOT_S1P1 : {s.slot[3:1], 1'b0} + 4'h2;
    end else begin
      n.slot = (s.slot >= SLOT_LAST) ? SLOT_S1P1 : s.slot + 4'h1;
    end
    if (mode == MODE_9FIX) begin
      if (s.pre >= lim) begin
        n.pre  = 2'h0;
        n.tick = 1'b1;
      end else begin
        n.pre = s.pre + 2'h1;
      end
    end else if (timer_ovf) begin
      // Halving only for 12-clock mode without doubling; 6-clock with
      // doubling cannot go above one tick per overflow
      if (!baud_double && !clk6_mode) begin
        n.half = ~s.half;
        n.tick = s.half;
      end else begin
        n.tick = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign slot   = s.slot;
  assign tick16 = s.tick;

endmodule : fsp_timing

/* File: verification/fsp_serial_port_props.sv */
// Pin-level checks for the four-mode serial port
module fsp_serial_port_props
  import fsp_pkg::*;
(
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic       SFR_WR,
  input wire logic       SFR_BIT_WR,
  input wire logic [2:0] SFR_BIT_SEL,
  input wire logic       SFR_BIT_VAL,
  input wire logic [7:0] SFR_RDATA,
  input wire logic       CLK6_MODE,
  input wire logic       RXD_OUT,
  input wire logic       RXD_OE_N,
  input wire logic       TXD
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------------------------------------------------
  // Mode shadow and properties
  // --------------------------------------------------------------
  logic [1:0] mode_r;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // Hardware never touches the mode bits; the shadow follows control byte writes, not bit writes
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      mode_r <= 2'h0;
    end else if (SFR_WR && SFR_ADDR == CTL_ADDR) begin
      mode_r <= SFR_WDATA[7:6];
    end
  end
  // Data pin driven only in shift mode
  oe_mode_a: assert property (!RXD_OE_N |-> mode_r == MODE_SHIFT)
    else $error("data pin driven outside shift mode");
  // Any async falling edge stays low for at least eight clocks
  start_len_a: assert property ($fell(TXD) && mode_r != MODE_SHIFT |-> !TXD [*8])
    else $error("async start bit too short");
  // Shift clock low for six clocks
  m0_low_a: assert property ($fell(TXD) && mode_r == MODE_SHIFT && !CLK6_MODE
    |-> !TXD [*6] ##1 TXD) else $error("shift clock low phase wrong");
  // Shift clock high for at least six clocks
  m0_high_a: assert property ($rose(TXD) && mode_r == MODE_SHIFT && !CLK6_MODE
    |-> TXD [*6]) else $error("shift clock high phase too short");
  // Data moves only while shift clock is high
  m0_data_a: assert property (!RXD_OE_N && $past(RXD_OE_N) == 1'b0
    && $changed(RXD_OUT) |-> TXD) else $error("shift data changed with clock low");
  unmapped_rd_a: assert property ($past(SFR_ADDR) != CTL_ADDR
    && $past(SFR_ADDR) != BUF_ADDR |-> SFR_RDATA == 8'h00) else $error("unmapped read not zero");
  ctl_wr_a: assert property (SFR_WR && !SFR_BIT_WR && SFR_ADDR == CTL_ADDR
    |=> (SFR_RDATA & 8'hf8) == ($past(SFR_WDATA) & 8'hf8)) else $error("control write lost");
  // Control bit write to bits 3 to 7 lands on its bit
  bit_wr_a: assert property (SFR_BIT_WR && SFR_ADDR == CTL_ADDR && SFR_BIT_SEL > 3'h2
    |=> SFR_RDATA[$past(SFR_BIT_SEL)] == $past(SFR_BIT_VAL)) else $error("bit write lost");
endmodule : fsp_serial_port_props

/* File: verification/fsp_remote_node.sv */
// Remote serial node on the port's data and clock lines
module fsp_remote_node
(
  input  wire logic clk,
  input  wire logic txd,
  input  wire logic rxd,
  output logic      rxd_drv
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------------------------------------------------
  // Frame tasks
  // --------------------------------------------------------------
  // Released line rests at the pulled-up level
  initial rxd_drv = 1'b1;
  // Start 0, n bits LSB first, then line back to 1
  task automatic send(input logic [9:0] b, input int n, input int p);
    rxd_drv = 1'b0;
    repeat (p) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      rxd_drv = b[i];
      repeat (p) @(negedge clk);
    end
    rxd_drv = 1'b1;
    repeat (p) @(negedge clk);
  endtask : send
  // Noise pulse shorter than the sample window
  task automatic glitch(input int w);
    rxd_drv = 1'b0;
    repeat (w) @(negedge clk);
    rxd_drv = 1'b1;
  endtask : glitch
  // Bit 0 must be 1: its rising edge sets the bit grid
  task automatic recv(output logic [9:0] b, input int n, input int p);
    int k;
    b = '0;
    for (k = 0; k < 3000 && txd; k++) @(negedge clk);
    for (k = 0; k < 200 && !txd; k++) @(negedge clk);
    repeat (p / 2) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      b[i] = txd;
      repeat (p) @(negedge clk);
    end
  endtask : recv
  // Shift-mode data taken on each rising shift clock
  task automatic m0_take(output logic [7:0] d);
    int k;
    d = '0;
    for (int i = 0; i < 8; i++) begin
      for (k = 0; k < 200 && txd; k++) @(negedge clk);
      for (k = 0; k < 100 && !txd; k++) @(negedge clk);
      d[i] = rxd;
    end
  endtask : m0_take
  // Next bit presented after each rising shift clock
  task automatic m0_give(input logic [7:0] d);
    int k;
    rxd_drv = d[0];
    for (int i = 1; i <= 8; i++) begin
      for (k = 0; k < 300 && txd; k++) @(negedge clk);
      for (k = 0; k < 100 && !txd; k++) @(negedge clk);
      rxd_drv = (i < 8) ? d[i] : 1'b1;
    end
  endtask : m0_give
endmodule : fsp_remote_node

/* File: verification/fsp_serial_port_tb.sv */
// Self-checking bench for the four-mode serial port
module fsp_serial_port_tb
  import fsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------------------------------------------------
  // Signals, clock and instances
  // --------------------------------------------------------------
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic       sfr_wr = 1'b0;
  logic       bit_wr = 1'b0;
  logic [2:0] bit_sel = 3'h0;
  logic       bit_val = 1'b0;
  logic       baud_double = 1'b1;
  logic       clk6_mode = 1'b0;
  logic       tovf = 1'b0;
  logic [7:0] sfr_rdata;
  logic       rxd_out;
  logic       oe_n;
  logic       txd;
  logic       rxd_drv;
  logic       rxd_line;
  int         failures = 0;
  int         checks = 0;
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
  always #50 clk = ~clk;
  // Overflow every other clock: with rate doubling one bit is 32 clocks
  always @(negedge clk) tovf <= ~tovf;
  // Device drive wins over the remote node while its enable is low
  assign rxd_line = oe_n ? rxd_drv : rxd_out;
  fsp_serial_port fsp_serial_port_i (.CLK(clk), .RST(rst), .SFR_ADDR(sfr_addr),
    .SFR_WDATA(sfr_wdata), .SFR_WR(sfr_wr), .SFR_BIT_WR(bit_wr), .SFR_BIT_SEL(bit_sel),
    .SFR_BIT_VAL(bit_val), .SFR_RDATA(sfr_rdata), .BAUD_DOUBLE(baud_double),
    .CLK6_MODE(clk6_mode), .TIMER_OVF(tovf), .RXD_IN(rxd_line), .RXD_OUT(rxd_out),
    .RXD_OE_N(oe_n), .TXD(txd));
  fsp_remote_node fsp_remote_node_i (.clk(clk), .txd(txd), .rxd(rxd_line), .rxd_drv(rxd_drv));
  // --------------------------------------------------------------
  // Register access and scenarios
  // --------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask : wr
  task automatic bwr(input logic [2:0] s, input logic v);
    @(negedge clk);
    sfr_addr = CTL_ADDR;
    bit_sel = s;
    bit_val = v;
    bit_wr = 1'b1;
    @(negedge clk);
    bit_wr = 1'b0;
  endtask : bwr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    @(negedge clk);
    d = sfr_rdata;
  endtask : rd
  // Polls one control flag; running out of patience ends the run
  task automatic wait_flag(input int b, output int n);
    sfr_addr = CTL_ADDR;
    for (n = 0; n < 3000; n++) begin
      @(negedge clk);
      if (sfr_rdata[b] === 1'b1) return;
    end
    failures++;
    conclude();
  endtask : wait_flag
  task automatic t_regs();
    logic [7:0] v;
    rd(CTL_ADDR, v);
    `CHK("control", CTL_RESET, v)
    rd(BUF_ADDR, v);
    `CHK("buffer", BUF_RESET, v)
    rd(8'h55, v);
    `CHK("unmapped", 8'h00, v)
    `CHK("idle line", 1'b1, txd)
    wr(CTL_ADDR, 8'hf8);
    bwr(3'h4, 1'b0);
    bwr(3'h1, 1'b1);
    rd(CTL_ADDR, v);
    `CHK("control", 8'hea, v)
  endtask : t_regs
  // Async transmit frame and done time
  task automatic t_tx(input logic [1:0] m, input logic t8, input logic [7:0] d);
    logic [9:0] got;
    logic [9:0] exp;
    int n;
    int nb;
    nb = (m == MODE_8VAR) ? 9 : 10;
    exp = (m == MODE_8VAR) ? {1'b0, 1'b1, d} : {1'b1, t8, d};
    wr(CTL_ADDR, {m, 2'b00, t8, 3'b000});
    fork
      fsp_remote_node_i.recv(got, nb, 32);
      begin
        wr(BUF_ADDR, d);
        wait_flag(1, n);
        @(negedge clk);
        `CHK("stop level", 1'b1, txd)
      end
    join
    `CHK("frame bits", exp, got)
    `CHK("done time", 1'b1, n >= nb * 32 - 4 && n <= nb * 32 + 36)
  endtask : t_tx
  // Fixed-rate bit width for each clock and doubling choice
  task automatic t_baud();
    int bw[4] = '{64, 32, 32, 16};
    int k;
    int w;
    for (int i = 0; i < 4; i++) begin
      clk6_mode = i[1];
      baud_double = i[0];
      wr(CTL_ADDR, {MODE_9FIX, 6'h00});
      wr(BUF_ADDR, 8'h01);
      for (k = 0; k < 2000 && txd; k++) @(negedge clk);
      for (k = 0; k < 200 && !txd; k++) @(negedge clk);
      for (w = 0; w < 200 && txd; w++) @(negedge clk);
      `CHK("bit clocks", bw[i], w)
      wait_flag(1, k);
      repeat (70) @(negedge clk);
    end
    clk6_mode = 1'b0;
    baud_double = 1'b1;
  endtask : t_baud
  task automatic t_rx(input logic [7:0] c, input logic [9:0] b, input int n, input int gl,
                      input logic [7:0] e_c, input logic [7:0] e_b);
    logic [7:0] v;
    wr(CTL_ADDR, c);
    if (gl > 0) begin
      fsp_remote_node_i.glitch(gl);
      repeat (64) @(negedge clk);
    end
    fsp_remote_node_i.send(b, n, 32);
    repeat (32) @(negedge clk);
    rd(CTL_ADDR, v);
    `CHK("control after frame", e_c, v)
    rd(BUF_ADDR, v);
    `CHK("buffer after frame", e_b, v)
  endtask : t_rx
  task automatic t_m0();
    logic [7:0] got;
    int n;
    wr(CTL_ADDR, 8'h00);
    fork
      fsp_remote_node_i.m0_take(got);
      begin
        wr(BUF_ADDR, 8'hc6);
        wait_flag(1, n);
      end
    join
    `CHK("shift out byte", 8'hc6, got)
    `CHK("shift out time", 1'b1, n >= 106 && n <= 124)
    fork
      fsp_remote_node_i.m0_give(8'h9a);
      begin
        wr(CTL_ADDR, 8'h10);
        wait_flag(0, n);
      end
    join
    rd(BUF_ADDR, got);
    `CHK("shift in byte", 8'h9a, got)
    `CHK("shift in time", 1'b1, n >= 106 && n <= 124)
    `CHK("pin released", 1'b1, oe_n)
  endtask : t_m0
  // Main sequence: ten reset clocks, then every scenario
  initial begin
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_regs();
    t_tx(MODE_8VAR, 1'b0, 8'h35);
    t_tx(MODE_9FIX, 1'b1, 8'ha5);
    t_tx(MODE_9VAR, 1'b0, 8'h6b);
    t_tx(MODE_9FIX, 1'b0, 8'h03);
    t_baud();
    t_rx(8'h50, {2'b01, 8'h5c}, 9, 0, 8'h55, 8'h5c);
    t_rx(8'h51, {2'b01, 8'h33}, 9, 0, 8'h51, 8'h5c);
    t_rx(8'hf0, {2'b10, 8'h12}, 10, 0, 8'hf0, 8'h5c);
    t_rx(8'hf0, {2'b11, 8'h9e}, 10, 0, 8'hf5, 8'h9e);
    t_rx(8'h90, {2'b10, 8'h47}, 10, 0, 8'h91, 8'h47);
    t_rx(8'h70, {2'b00, 8'ha6}, 9, 0, 8'h70, 8'h47);
    t_rx(8'h40, {2'b01, 8'h3c}, 9, 0, 8'h40, 8'h47);
    t_rx(8'h50, {2'b01, 8'h81}, 9, 4, 8'h55, 8'h81);
    t_m0();
    conclude();
  end
endmodule : fsp_serial_port_tb

bind fsp_serial_port fsp_serial_port_props fsp_serial_port_props_i (.CLK(CLK), .RST(RST),
  .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA), .SFR_WR(SFR_WR), .SFR_BIT_WR(SFR_BIT_WR),
  .SFR_BIT_SEL(SFR_BIT_SEL), .SFR_BIT_VAL(SFR_BIT_VAL), .SFR_RDATA(SFR_RDATA),
  .CLK6_MODE(CLK6_MODE), .RXD_OUT(RXD_OUT), .RXD_OE_N(RXD_OE_N), .TXD(TXD));
